// [rtl/sfs_state.sv]
/*
  Segment selector and program flags state: six selectors, the program flags
  register with wide-mode view, address base selection and flags save/restore.
  Assumes execution logic supplies descriptor bases, the instruction offset and
  one request per kind per cycle; hard reset covers every register, warm init only the selectors and flags.
*/
// How it works
// - Six 16-bit selectors: code, stack and four data.
// - Fetch address pairs code selector with the instruction offset.
// - Explicit code selector loads are refused; control transfers load it.
// - Stack accesses always take the stack selector and its base.
// - Explicit stack selector loads are accepted.
// - Wide mode forces zero base for code, stack and first two data selectors.
// - Wide mode keeps the auxiliary data selector bases.
// - Selector loads still pass legacy validity checks in wide mode.
// - Wide mode skips limit checks for all six selectors.
// - Hard reset or warm init sets flags to 0x00000002.
// - Bits 1, 3, 5, 15, 22..31 are reserved.
// - No whole-register access; flags move via stack or accumulator only.
// - Task suspend stores flags to the task state area.
// - Task switch reloads flags from the new task state area.
// - Handler call pushes flags onto the procedure stack.
// - Handler via task switch stores flags in the task state area instead.
// - Wide mode shows 64-bit flags with zero reserved upper half.
`timescale 1ns/1ns
`include "sfs_defines.svh"

module sfs_state
  import sfs_pkg::*;
#(
  parameter int ADDR_W = 64,
  parameter int OFF_W  = 64
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     initWarm,
  input  wire logic                     wideMode,
  input  wire sfs_sel_load_t            selLoad,
  input  wire sfs_xfer_t                codeXfer,
  input  wire sfs_flag_req_t            flagReq,
  input  wire logic [OFF_W-1:0]         instructionOffset,
  input  wire logic [ADDR_W-1:0]        descBase [`SFS_NUM_SEL],
  input  wire logic [2:0]               memSelIndex,
  input  wire logic                     memIsStack,
  input  wire logic [ADDR_W-1:0]        memOffset,
  output logic [`SFS_SEL_W-1:0]         selector_q [`SFS_NUM_SEL],
  output logic [`SFS_SEL_W-1:0]         fetchSelector_q,
  output logic [OFF_W-1:0]              fetchOffset_q,
  output logic [ADDR_W-1:0]             linearAddr_q,
  output logic [2:0]                    usedSelIndex_q,
  output logic                          limitCheckEn_q,
  output logic                          selLoadRefused_q,
  output logic                          selLoadFault_q,
  output logic [`SFS_WFLAGS_W-1:0]      wideProgramFlags_q,
  output logic [7:0]                    accumulatorFlags_q,
  output sfs_flag_save_t                flagSave_q
);

  // Elaboration guards: the legacy adder and the fetch pair need 32 bits at least
  if (ADDR_W < 32)
  begin : gAddrWidthCheck
    $error("sfs_state: address width below 32 unsupported");
  end
  if (OFF_W < 32)
  begin : gOffWidthCheck
    $error("sfs_state: offset width below 32 unsupported");
  end
  // The wide flags view is the flags register with a reserved upper half
  if (`SFS_WFLAGS_W != 2 * `SFS_FLAGS_W)
  begin : gWideFlagsCheck
    $error("sfs_state: wide flags must be twice the flags width");
  end
  // Selector indices are three bits wide, so the selector count must fit
  if (`SFS_NUM_SEL > 8)
  begin : gSelCountCheck
    $error("sfs_state: selector count exceeds the index range");
  end
  // Masked loads rebuild the reset image from reserved bits only
  if ((`SFS_FLAGS_RESET & ~`SFS_FLAGS_RSVD) != 32'h0000_0000)
  begin : gResetMaskCheck
    $error("sfs_state: flags reset value outside the reserved layout");
  end

  logic [`SFS_FLAGS_W-1:0] programFlags_q;
  logic [`SFS_FLAGS_W-1:0] programFlags_d;
  logic                    initSyncA_q;
  logic                    initSyncB_q;
  logic                    initSyncC_q;

  // Warm init arrives from a pin: three stages, init level active while B and C are both high
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      initSyncA_q <= 1'b0;
      initSyncB_q <= 1'b0;
      initSyncC_q <= 1'b0;
    end
    else
    begin
      initSyncA_q <= initWarm;
      initSyncB_q <= initSyncA_q;
      initSyncC_q <= initSyncB_q;
    end
  end

  // Init acts while held; a single-sample glitch on the pin never reaches it
  wire initHit = initSyncB_q && initSyncC_q;

  // Explicit load decode: code index and indices past the last selector refused, others accepted
  wire loadCode   = selLoad.valid && (selLoad.index == `SFS_IDX_CODE);
  wire loadBadIdx = selLoad.valid && (selLoad.index >= 3'(`SFS_NUM_SEL));
  wire loadOk     = selLoad.valid && !loadCode && !loadBadIdx;

  // Legacy checks on every accepted explicit load, independent of mode
  sfs_sel_check #(.SEL_W(`SFS_SEL_W)) uCheck
  (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .chkValid   (loadOk),
    .chkIndex   (selLoad.index),
    .chkValue   (selLoad.value),
    .chkFault_q (selLoadFault_q)
  );

  // One register per selector; code only moves via control transfer
  for (genvar i = 0; i < `SFS_NUM_SEL; i++)
  begin : gSel
    wire explicitHit = loadOk && (selLoad.index == 3'(i));
    wire implicitHit = (i == 0) && codeXfer.valid;
    always_ff @(posedge clk_sys)
    begin
      if (rst || initHit)
        selector_q[i] <= `SFS_SEL_RESET;
      else if (implicitHit)
        selector_q[i] <= codeXfer.value;
      else if (explicitHit)
        selector_q[i] <= selLoad.value;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      selLoadRefused_q <= 1'b0;
    else
      selLoadRefused_q <= loadCode || loadBadIdx;
  end

  // Stack accesses ignore the requested selector and use the stack one
  wire [2:0] effIndex = memIsStack ? `SFS_IDX_STACK : memSelIndex;
  wire       effLegal = (effIndex < 3'(`SFS_NUM_SEL));
  wire [ADDR_W-1:0] rawBase = effLegal ? descBase[effIndex] : '0;

  // Per-selector base as wide mode sees it: all but the auxiliary pair go flat
  logic [ADDR_W-1:0] flatBase [`SFS_NUM_SEL];
  for (genvar j = 0; j < `SFS_NUM_SEL; j++)
  begin : gBase
    localparam bit isAux = (j == `SFS_IDX_AUX1) || (j == `SFS_IDX_AUX2);
    assign flatBase[j] = (wideMode && !isAux) ? '0 : descBase[j];
  end

  wire [ADDR_W-1:0] effBase = effLegal ? flatBase[effIndex] : '0;
  wire [ADDR_W-1:0] legacySum = ADDR_W'(32'(rawBase) + 32'(memOffset));
  wire [ADDR_W-1:0] wideSum   = effBase + memOffset;
  wire [ADDR_W-1:0] linNext   = wideMode ? wideSum : legacySum;

  // Fetch pair: code selector with the instruction offset, one cycle behind
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fetchSelector_q <= `SFS_SEL_RESET;
      fetchOffset_q   <= '0;
    end
    else
    begin
      fetchSelector_q <= selector_q[0];
      fetchOffset_q   <= instructionOffset;
    end
  end

  // Data access address; registered so the wide adder has a full cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      linearAddr_q <= '0;
    else
      linearAddr_q <= linNext;
  end

  // Selector actually used and whether limit checks apply to this access
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      usedSelIndex_q <= `SFS_IDX_CODE;
      limitCheckEn_q <= 1'b1;
    end
    else
    begin
      usedSelIndex_q <= effIndex;
      limitCheckEn_q <= !wideMode;
    end
  end

  // Flags update: only group moves, each masked so reserved bits keep reset values
  wire [`SFS_FLAGS_W-1:0] keepMask = `SFS_FLAGS_RSVD;
  wire [`SFS_FLAGS_W-1:0] rsvdVal  = `SFS_FLAGS_RESET & `SFS_FLAGS_RSVD;
  wire [`SFS_FLAGS_W-1:0] cleanIn  = (flagReq.data & ~keepMask) | rsvdVal;
  wire [`SFS_FLAGS_W-1:0] lowMerge =
    (programFlags_q & ~`SFS_LOWGRP_MASK) | (cleanIn & `SFS_LOWGRP_MASK);

  always_comb
  begin
    programFlags_d = programFlags_q;
    unique case (flagReq.op)
      SFS_FOP_POP_STACK:  programFlags_d = cleanIn;
      SFS_FOP_LOAD_ACC:   programFlags_d = lowMerge;
      SFS_FOP_TASK_LOAD:  programFlags_d = cleanIn;
      SFS_FOP_NONE,
      SFS_FOP_HANDLER_CALL,
      SFS_FOP_HANDLER_TASK,
      SFS_FOP_TASK_SUSPEND,
      SFS_FOP_PUSH_STACK: programFlags_d = programFlags_q;
    endcase
  end

  // Hard reset and warm init both restore the defined flags value
  always_ff @(posedge clk_sys)
  begin
    if (rst || initHit)
      programFlags_q <= `SFS_FLAGS_RESET;
    else
      programFlags_q <= programFlags_d;
  end

  // Upper half of the wide view is reserved and reads zero in every mode
  wire [`SFS_WFLAGS_W-1:0] wideNext = {32'h0000_0000, programFlags_d};

  always_ff @(posedge clk_sys)
  begin
    if (rst || initHit)
      wideProgramFlags_q <= {32'h0000_0000, `SFS_FLAGS_RESET};
    else
      wideProgramFlags_q <= wideNext;
  end

  // Outgoing images snapshot the current flags before any same-cycle change
  wire toStackNow = (flagReq.op == SFS_FOP_HANDLER_CALL) ||
                    (flagReq.op == SFS_FOP_PUSH_STACK);
  wire toTaskNow  = (flagReq.op == SFS_FOP_TASK_SUSPEND) ||
                    (flagReq.op == SFS_FOP_HANDLER_TASK);
  wire saveNow    = toStackNow || toTaskNow;
  wire [`SFS_FLAGS_W-1:0] saveData = saveNow ? programFlags_q : '0;

  // A push in the same cycle as a reload still carries the old image
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      flagSave_q <= '0;
    else
      flagSave_q <= '{toStackNow, toTaskNow, saveData};
  end

  // Low flag byte for the accumulator group move; it follows warm init too,
  // so it never shows a byte that the flags register did not take
  always_ff @(posedge clk_sys)
  begin
    if (rst || initHit)
      accumulatorFlags_q <= 8'(`SFS_FLAGS_RESET);
    else
      accumulatorFlags_q <= programFlags_d[7:0];
  end

endmodule

// [rtl/sfs_defines.svh]
/*
  Constants for the segment selector and flags state block: selector indices,
  flag field positions, reset values and masks.
  Assumes inclusion by its bare name from the package and the design files.
*/
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

`define SFS_SEL_W          16
`define SFS_FLAGS_W        32
`define SFS_WFLAGS_W       64
`define SFS_NUM_SEL        6
// Selector indices
`define SFS_IDX_CODE       3'h0
`define SFS_IDX_STACK      3'h1
`define SFS_IDX_DPRIM      3'h2
`define SFS_IDX_DEXTRA     3'h3
`define SFS_IDX_AUX1       3'h4
`define SFS_IDX_AUX2       3'h5
// Flags reset value and reserved layout (bits 1,3,5,15,22..31)
`define SFS_FLAGS_RESET    32'h0000_0002
`define SFS_FLAGS_RSVD     32'hFFC0_802A
// Low byte group moved to and from the accumulator
`define SFS_LOWGRP_MASK    32'h0000_00FF
`define SFS_SEL_RESET      16'h0000

`endif

// [rtl/sfs_pkg.sv]
/*
  Types shared by the segment selector and flags state block.
  Assumes sfs_defines.svh is reachable on the include path.
*/
`include "sfs_defines.svh"

package sfs_pkg;

  // Flag transfer operations issued by execution logic
  typedef enum logic [2:0] {
    SFS_FOP_NONE,
    SFS_FOP_POP_STACK,
    SFS_FOP_LOAD_ACC,
    SFS_FOP_TASK_LOAD,
    SFS_FOP_HANDLER_CALL,
    SFS_FOP_HANDLER_TASK,
    SFS_FOP_TASK_SUSPEND,
    SFS_FOP_PUSH_STACK
  } sfs_fop_t;

  // Explicit selector load request from an instruction
  typedef struct packed {
    logic                    valid;
    logic [2:0]              index;
    logic [`SFS_SEL_W-1:0]   value;
  } sfs_sel_load_t;

  // Implicit code selector load by a control transfer
  typedef struct packed {
    logic                    valid;
    logic [`SFS_SEL_W-1:0]   value;
  } sfs_xfer_t;

  // Flags move request
  typedef struct packed {
    sfs_fop_t                op;
    logic [`SFS_FLAGS_W-1:0] data;
  } sfs_flag_req_t;

  // Outgoing flags image to stack or task state area
  typedef struct packed {
    logic                    toStack;
    logic                    toTaskArea;
    logic [`SFS_FLAGS_W-1:0] data;
  } sfs_flag_save_t;

endpackage

// [rtl/sfs_sel_check.sv]
/*
  Selector validity check applied to every accepted explicit selector load, in any mode.
  Assumes a registered result is acceptable one cycle after the request.
*/
`timescale 1ns/1ns
`include "sfs_defines.svh"

module sfs_sel_check
  import sfs_pkg::*;
#(
  parameter int SEL_W = `SFS_SEL_W
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             chkValid,
  input  wire logic [2:0]       chkIndex,
  input  wire logic [SEL_W-1:0] chkValue,
  output logic                  chkFault_q
);

  // Elaboration guard: the null test and the load path assume the selector width
  if (SEL_W != `SFS_SEL_W)
  begin : gWidthCheck
    $error("sfs_sel_check: selector width must match the selector registers");
  end

  // Null selector raises a fault for the stack, which needs a real segment
  wire nullSel    = (chkValue[SEL_W-1:2] == '0);
  wire stackNull  = (chkIndex == `SFS_IDX_STACK) && nullSel;
  wire badIndex   = (chkIndex >= 3'(`SFS_NUM_SEL));
  wire faultNow   = chkValid && (stackNull || badIndex);

  // Legacy checks stay active in wide mode
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      chkFault_q <= 1'b0;
    else
      chkFault_q <= faultNow;
  end

endmodule

// [test/sfs_exec_model.sv]
/* Execution-side model: descriptor bases and a running instruction offset.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module sfs_exec_model
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  output logic [63:0]      descBase [6],
  output logic [63:0]      instructionOffset
);
  // Upper bits set so a short adder in the base path shows up
  always_comb
  begin
    for (int i = 0; i < 6; i++)
      descBase[i] = {32'(i + 1), 32'h0000_1000};
  end

  // Offset steps one instruction boundary per cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      instructionOffset <= 64'h0;
    else
      instructionOffset <= instructionOffset + 64'h4;
  end
endmodule

// [test/sfs_state_asserts.sv]
/* Port checker for sfs_state.
   Assumes binding by name onto every sfs_state instance. */
`timescale 1ns/1ns
`include "sfs_defines.svh"
module sfs_state_asserts
  import sfs_pkg::*;
#(
  parameter int ADDR_W = 64,
  parameter int OFF_W  = 64
)
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              wideMode,
  input wire sfs_sel_load_t     selLoad,
  input wire sfs_xfer_t         codeXfer,
  input wire sfs_flag_req_t     flagReq,
  input wire logic [OFF_W-1:0]  instructionOffset,
  input wire logic [ADDR_W-1:0] descBase [`SFS_NUM_SEL],
  input wire logic [2:0]        memSelIndex,
  input wire logic              memIsStack,
  input wire logic [ADDR_W-1:0] memOffset,
  input wire logic [15:0]       selector_q [`SFS_NUM_SEL],
  input wire logic [OFF_W-1:0]  fetchOffset_q,
  input wire logic [ADDR_W-1:0] linearAddr_q,
  input wire logic [2:0]        usedSelIndex_q,
  input wire logic              selLoadRefused_q,
  input wire logic [63:0]       wideProgramFlags_q,
  input wire sfs_flag_save_t    flagSave_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Decoded request kinds
  wire logic [31:0] flg = wideProgramFlags_q[31:0];
  wire logic sLd = selLoad.valid && !codeXfer.valid;
  wire logic wA = wideMode && !memIsStack && memSelIndex > 3'h3 && memSelIndex < 3'h6;
  sequence saved_s(logic st, logic [31:0] d);
    flagSave_q.toStack == st && flagSave_q.toTaskArea == !st && flagSave_q.data == d;
  endsequence

  flags_rsvd_a:
    assert property (((flg ^ `SFS_FLAGS_RESET) & `SFS_FLAGS_RSVD) == 0 &&
      wideProgramFlags_q[63:32] == 0) else $error("reserved flag bits moved");
  code_refuse_a:
    assert property (sLd && (selLoad.index == 3'h0 || selLoad.index > 3'h5) |=>
      selLoadRefused_q && $stable(selector_q[0])) else $error("bad selector load taken");
  code_xfer_a:
    assert property (codeXfer.valid |=> selector_q[0] == $past(codeXfer.value))
    else $error("control transfer lost");
  stack_load_a:
    assert property (sLd && selLoad.index == 3'h1 && selLoad.value[15:2] != 0 |=>
      selector_q[1] == $past(selLoad.value)) else $error("stack load lost");
  stack_use_a:
    assert property (memIsStack |=> usedSelIndex_q == 3'h1) else $error("stack not used");
  fetch_pair_a:
    assert property (1'b1 |=> fetchOffset_q == $past(instructionOffset))
    else $error("fetch offset wrong");
  flat_base_a:
    assert property (wideMode && (memIsStack || memSelIndex < 3'h4) |=>
      linearAddr_q == $past(memOffset)) else $error("base not zero");
  aux_base_a:
    assert property (wA |=> linearAddr_q == $past(descBase[memSelIndex]) + $past(memOffset))
    else $error("aux base dropped");
  handler_push_a:
    assert property (flagReq.op == SFS_FOP_HANDLER_CALL |=> saved_s(1'b1, $past(flg)))
    else $error("flags not pushed");
  task_save_a:
    assert property (flagReq.op inside {SFS_FOP_TASK_SUSPEND, SFS_FOP_HANDLER_TASK} |=>
      saved_s(1'b0, $past(flg))) else $error("flags not saved");
  task_load_a:
    assert property (flagReq.op == SFS_FOP_TASK_LOAD |=> flg == ($past(flagReq.data) &
      ~`SFS_FLAGS_RSVD | `SFS_FLAGS_RESET)) else $error("flags not reloaded");
endmodule

bind sfs_state sfs_state_asserts #(.ADDR_W(ADDR_W), .OFF_W(OFF_W)) u_sfs_state_asserts (
  .clk_sys, .rst, .wideMode, .selLoad, .codeXfer, .flagReq, .instructionOffset,
  .descBase, .memSelIndex, .memIsStack, .memOffset, .selector_q, .fetchOffset_q,
  .linearAddr_q, .usedSelIndex_q, .selLoadRefused_q, .wideProgramFlags_q, .flagSave_q);

// [test/sfs_state_tb_top.sv]
/* Directed bench for sfs_state with the execution-side model.
   Assumes the checker binds itself. */
`timescale 1ns/1ns
`include "sfs_defines.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, e); end end
module sfs_state_tb_top;
  import sfs_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, initWarm = 1'b0, wideMode = 1'b0, memIsStack = 1'b0;
  sfs_sel_load_t selLoad = '0;
  sfs_xfer_t codeXfer = '0;
  sfs_flag_req_t flagReq = '0;
  logic [2:0] memSelIndex = 3'h0, usedSelIndex_q;
  logic [63:0] memOffset = 64'h0, descBase [6], instructionOffset, linearAddr_q, wFlags;
  logic [15:0] selector_q [6];
  logic refused, fault, limitEn;
  logic [7:0] accFlags;
  logic [15:0] fetchSel;
  sfs_flag_save_t flagSave_q;
  logic [31:0] exp;
  sfs_fop_t ops [4] = '{SFS_FOP_HANDLER_CALL, SFS_FOP_PUSH_STACK, SFS_FOP_HANDLER_TASK,
    SFS_FOP_TASK_SUSPEND};
  int fails = 0, checks_done = 0;

  always #4 clk_sys = ~clk_sys;

  sfs_exec_model u_sfs_exec_model (.clk_sys, .rst, .descBase, .instructionOffset);
  sfs_state u_sfs_state (.clk_sys, .rst, .initWarm, .wideMode, .selLoad, .codeXfer,
    .flagReq, .instructionOffset, .descBase, .memSelIndex, .memIsStack, .memOffset,
    .selector_q, .fetchSelector_q(fetchSel), .fetchOffset_q(), .linearAddr_q, .usedSelIndex_q,
    .limitCheckEn_q(limitEn), .selLoadRefused_q(refused), .selLoadFault_q(fault),
    .wideProgramFlags_q(wFlags), .accumulatorFlags_q(accFlags), .flagSave_q);

  // Taking edge, drop the pulse requests, let results land
  task automatic tick();
    @(posedge clk_sys);
    selLoad <= '0;
    codeXfer <= '0;
    flagReq <= '0;
    #1;
  endtask
  task automatic sel(input logic [2:0] i, input logic [15:0] v);
    @(posedge clk_sys);
    selLoad <= '{1'b1, i, v};
    tick();
  endtask
  task automatic fop(input sfs_fop_t o, input logic [31:0] d);
    @(posedge clk_sys);
    flagReq <= '{o, d};
    tick();
  endtask
  task automatic mem(input logic s, input logic [2:0] i, input logic [63:0] o);
    @(posedge clk_sys);
    memIsStack <= s;
    memSelIndex <= i;
    memOffset <= o;
    tick();
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Run is about 70 cycles, so this only trips on a hang
  initial
  begin
    repeat (1000) @(posedge clk_sys);
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK(wFlags, 64'h2)
    `CHK(limitEn, 1'b1)
    $display("reset test done");
    for (int i = 1; i < 6; i++)
    begin
      sel(3'(i), 16'h1230 + 16'(i));
      `CHK(selector_q[i], 16'h1230 + 16'(i))
    end
    sel(3'h0, 16'hBEE8);
    `CHK({refused, selector_q[0]}, 17'h10000)
    sel(3'h6, 16'h0044);
    `CHK(refused, 1'b1)
    @(posedge clk_sys);
    codeXfer <= '{1'b1, 16'h0F08};
    tick();
    `CHK(selector_q[0], 16'h0F08)
    @(posedge clk_sys);
    #1;
    `CHK(fetchSel, 16'h0F08)
    @(posedge clk_sys);
    wideMode <= 1'b1;
    sel(3'h1, 16'h0003);
    `CHK(fault, 1'b1)
    $display("selector test done");
    for (int i = 0; i < 6; i++)
    begin
      mem(1'b0, 3'(i), 64'h40);
      `CHK(linearAddr_q, (i < 4) ? 64'h40 : descBase[i] + 64'h40)
    end
    `CHK(limitEn, 1'b0)
    mem(1'b1, 3'h4, 64'h80);
    `CHK({usedSelIndex_q, linearAddr_q}, {3'h1, 64'h80})
    @(posedge clk_sys);
    wideMode <= 1'b0;
    mem(1'b0, 3'h2, 64'h40);
    `CHK({limitEn, linearAddr_q}, {1'b1, 32'h0, descBase[2][31:0] + 32'h40})
    $display("address test done");
    fop(SFS_FOP_TASK_LOAD, 32'hFFFF_FFFF);
    exp = ~`SFS_FLAGS_RSVD | `SFS_FLAGS_RESET;
    `CHK(wFlags, {32'h0, exp})
    fop(SFS_FOP_LOAD_ACC, 32'h0);
    exp = exp & ~32'hFF | 32'h2;
    `CHK({accFlags, wFlags[31:0]}, {exp[7:0], exp})
    for (int k = 0; k < 4; k++)
    begin
      fop(ops[k], 32'h0);
      `CHK(flagSave_q, {k < 2, k > 1, exp})
    end
    @(posedge clk_sys);
    initWarm <= 1'b1;
    repeat (4) @(posedge clk_sys);
    fop(SFS_FOP_LOAD_ACC, 32'h0000_00FF);
    `CHK({wFlags, selector_q[1], accFlags}, {64'h2, 16'h0, 8'h02})
    @(posedge clk_sys);
    initWarm <= 1'b0;
    repeat (4) @(posedge clk_sys);
    fop(SFS_FOP_POP_STACK, 32'hFFFF_0ED5);
    `CHK(wFlags[31:0], 32'hFFFF_0ED5 & ~`SFS_FLAGS_RSVD | 32'h2)
    $display("flags test done");
    end_of_test();
  end
endmodule
